// [inc/power_pkg.sv]
package power_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry and answers
  localparam int        ADDR_WIDTH = 8;
  localparam int        DATA_WIDTH = 32;
  localparam logic[1:0] RESP_OKAY   = 2'h0;
  localparam logic[1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Register word indices; byte address is four times the index
  localparam logic[2:0] IDX_LOW_POWER = 3'h0;
  localparam logic[2:0] IDX_STANDBY   = 3'h1;
  localparam logic[2:0] IDX_STOP_A    = 3'h2;
  localparam logic[2:0] IDX_STATUS    = 3'h5;
  localparam logic[2:0] IDX_NONE      = 3'h7;
  localparam int        STOP_BANKS    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int         SOFTWARE_STANDBY_BIT = 7;
  localparam int         STANDBY_LOW_BIT      = 3;
  localparam logic [7:0] LOW_POWER_RESET      = 8'h00;
  localparam logic [4:0] STANDBY_RESET        = 5'h01;
  localparam logic[23:0] STOP_RESET           = 24'hFFFF3F;

  ////////////////////////////////////////////////////////////////////////////
  // Multiplier codes
  localparam logic [1:0] PLL_X1         = 2'h0;
  localparam logic [1:0] PLL_X2         = 2'h1;
  localparam logic [1:0] PLL_X4         = 2'h2;
  localparam logic [1:0] PLL_PROHIBITED = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic       direct_transition_flag;
    logic       low_speed_flag;
    logic       reserved_5;
    logic       subclock_stop_bit;
    logic       feedback_cut_bit;
    logic       reserved_2;
    logic [1:0] pll_factor;
  } low_power_control_type;

  typedef enum logic [2:0] {
    st_active,
    st_sleep,
    st_standby,
    st_watch,
    st_subactive,
    st_subsleep
  } power_state_type;

  typedef struct packed {
    logic       cpu_clock_stop;
    logic       main_osc_enable;
    logic       subclock_enable;
    logic       feedback_resistor_on;
    logic       medium_speed;
    logic [1:0] pll_factor;
  } power_ctrl_type;

  localparam power_ctrl_type POWER_RESET = 7'h3C;

endpackage

// [design/module_stop_bank.sv]
module module_stop_bank (
  // Clock, reset and enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Register write
  input  wire logic        write_strobe,
  input  wire logic [2:0]  write_index,
  input  wire logic [7:0]  write_data,
  // Stop levels to the modules
  output logic      [23:0] module_stop
);

  ////////////////////////////////////////////////////////////////////////////
  // One byte per bank; a 1 holds the module stopped, a 0 lets it run
  genvar i;
  generate
    for (i = 0; i < power_pkg::STOP_BANKS; i++)
    begin : bank
      localparam logic [2:0] MY_INDEX = 3'(power_pkg::IDX_STOP_A + i);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          module_stop[i*8 +: 8] <= power_pkg::STOP_RESET[i*8 +: 8];
        else if (ce && write_strobe && write_index == MY_INDEX)
          module_stop[i*8 +: 8] <= write_data;
      end
    end
  endgenerate

endmodule

// [design/low_power_mode_control.sv]
// Function
// - Direct flag 0, sleep from high/medium speed: sleep, standby or watch.
// - Direct flag 0, sleep from subactive: subsleep or watch.
// - Direct flag 1, sleep from high/medium: subactive directly, else sleep/standby.
// - Direct flag 1, sleep from subactive: high speed directly, else subsleep or watch.
// - Low-speed 0: subactive sleep gives watch or high speed; watch wakes high.
// - Low-speed 1: watch or subactive from high; watch wakes to subactive.
// - Reserved bits 5 and 2 store and read back; software writes 0.
// - Subclock stop bit 0 enables subclock, 1 disables it.
// - Cut bit 0: feedback resistor on while main oscillator runs, else off.
// - Cut bit 1 turns resistor off; change applies at standby entry or exit.
// - Multiplier code 00 x1, 01 x2, 10 x4; code 11 is forbidden.
// - Writing 1 to a module stop bit stops that module.
// - Writing 0 to a module stop bit releases that module.
// - Standby bit with low-speed and direct flags picks the sleep target.
module low_power_mode_control (
  // Clock, reset and enable
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  // AXI4-Lite write address and data
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [7:0]             awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  // AXI4-Lite write response
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // AXI4-Lite read
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [7:0]             araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // CPU events
  input  wire logic                   sleep_exec,
  input  wire logic                   wake_request,
  input  wire logic                   medium_speed_request,
  // Power and clock controls
  output power_pkg::power_ctrl_type   power,
  output logic [23:0]                 module_stop
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding used by both bus channels
  function automatic logic [2:0] reg_select(input logic [7:0] addr);
    reg_select = power_pkg::IDX_NONE;
    if (addr[7:5] == 3'h0 && addr[4:2] <= power_pkg::IDX_STATUS)
      reg_select = addr[4:2];
  endfunction

  // Target of a sleep instruction from a running state
  function automatic power_pkg::power_state_type sleep_target(
    input power_pkg::power_state_type from,
    input power_pkg::low_power_control_type c,
    input logic                            standby
  );
    sleep_target = from;
    if (from == power_pkg::st_active)
    begin
      if (!standby)
        sleep_target = power_pkg::st_sleep;
      else if (!c.low_speed_flag)
        sleep_target = power_pkg::st_standby;
      else if (!c.direct_transition_flag)
        sleep_target = power_pkg::st_watch;
      else
        sleep_target = power_pkg::st_subactive;
    end
    else if (from == power_pkg::st_subactive)
    begin
      if (!standby)
        sleep_target = power_pkg::st_subsleep;
      else if (c.direct_transition_flag && !c.low_speed_flag)
        sleep_target = power_pkg::st_active;
      else
        sleep_target = power_pkg::st_watch;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  power_pkg::low_power_control_type lpc;
  power_pkg::power_state_type       state;
  power_pkg::power_state_type       next_state;
  logic [4:0]                       standby_ctrl;
  logic                             software_standby_bit;
  logic                             fb_cut_eff;
  logic                             aw_held;
  logic                             w_held;
  logic [7:0]                       aw_addr;
  logic [31:0]                      w_data;
  logic [3:0]                       w_strb;
  logic                             do_write;
  logic [2:0]                       write_sel;
  logic                             lane0;
  logic                             lpc_write;
  logic                             osc_running;
  logic                             standby_edge;

  assign software_standby_bit = standby_ctrl[power_pkg::SOFTWARE_STANDBY_BIT -
                             power_pkg::STANDBY_LOW_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order
  assign awready   = ce && !aw_held && !bvalid;
  assign wready    = ce && !w_held && !bvalid;
  assign do_write  = aw_held && w_held;
  assign write_sel = reg_select(aw_addr);
  assign lane0     = do_write && w_strb[0];
  assign lpc_write = lane0 && write_sel == power_pkg::IDX_LOW_POWER;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'h0;
      aw_addr <= 8'h00;
    end
    else if (ce)
    begin
      if (do_write)
        aw_held <= 1'h0;
      else if (awvalid && awready)
      begin
        aw_held <= 1'h1;
        aw_addr <= awaddr;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (ce)
    begin
      if (do_write)
        w_held <= 1'h0;
      else if (wvalid && wready)
      begin
        w_held <= 1'h1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  // Response waits for both halves, so one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'h0;
      bresp  <= power_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (do_write)
      begin
        bvalid <= 1'h1;
        bresp  <= (write_sel == power_pkg::IDX_NONE) ?
                  power_pkg::RESP_DECERR : power_pkg::RESP_OKAY;
      end
      else if (bready)
        bvalid <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; only byte lane 0 carries register bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lpc <= power_pkg::LOW_POWER_RESET;
    else if (ce && lpc_write)
      lpc <= w_data[7:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      standby_ctrl <= power_pkg::STANDBY_RESET;
    else if (ce && lane0 && write_sel == power_pkg::IDX_STANDBY)
      standby_ctrl <= w_data[7:power_pkg::STANDBY_LOW_BIT];
  end

  module_stop_bank stop_bank (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ce           (ce),
    .write_strobe (lane0),
    .write_index  (write_sel),
    .write_data   (w_data[7:0]),
    .module_stop  (module_stop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: data one cycle after the address is taken
  assign arready = ce && !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'h0;
      rdata  <= 32'h00000000;
      rresp  <= power_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid <= 1'h1;
        rresp  <= power_pkg::RESP_OKAY;
        rdata  <= 32'h00000000;
        case (reg_select(araddr))
          power_pkg::IDX_LOW_POWER: rdata[7:0] <= lpc;
          power_pkg::IDX_STANDBY:
            rdata[7:0] <= {standby_ctrl, 3'h0};
          power_pkg::IDX_STATUS:
            rdata[7:0] <= {3'h0, fb_cut_eff, power.medium_speed, state};
          power_pkg::IDX_NONE: rresp <= power_pkg::RESP_DECERR;
          default:
            rdata[7:0] <= module_stop[(araddr[4:2] - 3'h2)*8 +: 8];
        endcase
      end
      else if (rready)
        rvalid <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer; medium speed is the active state with a slow CPU clock,
  // so sleep and standby from medium speed come back to medium speed
  always_comb
  begin
    next_state = state;
    case (state)
      power_pkg::st_active,
      power_pkg::st_subactive:
        if (sleep_exec)
          next_state = sleep_target(state, lpc, software_standby_bit);
      power_pkg::st_sleep,
      power_pkg::st_standby:
        if (wake_request)
          next_state = power_pkg::st_active;
      power_pkg::st_subsleep:
        if (wake_request)
          next_state = power_pkg::st_subactive;
      power_pkg::st_watch:
        if (wake_request)
          next_state = lpc.low_speed_flag ? power_pkg::st_subactive :
                                            power_pkg::st_active;
      default:
        next_state = power_pkg::st_active;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= power_pkg::st_active;
    else if (ce)
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feedback cut is sampled only at standby entry and exit, so a write while
  // the crystal runs cannot kill it mid-operation
  assign standby_edge = (next_state == power_pkg::st_standby) !=
                        (state == power_pkg::st_standby);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fb_cut_eff <= 1'h0;
    else if (ce && standby_edge)
      fb_cut_eff <= lpc.feedback_cut_bit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered controls; they lag the state by one cycle
  assign osc_running = state == power_pkg::st_active ||
                       state == power_pkg::st_sleep;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      power <= power_pkg::POWER_RESET;
    else if (ce)
    begin
      power.cpu_clock_stop       <= !(state == power_pkg::st_active ||
                                      state == power_pkg::st_subactive);
      power.main_osc_enable      <= osc_running;
      power.subclock_enable      <= !lpc.subclock_stop_bit;
      power.feedback_resistor_on <= osc_running && !fb_cut_eff;
      power.medium_speed         <= state == power_pkg::st_active &&
                                    medium_speed_request;
      // A forbidden code falls back to x1 rather than overdrive the PLL
      power.pll_factor           <=
        (lpc.pll_factor == power_pkg::PLL_PROHIBITED) ?
        power_pkg::PLL_X1 : lpc.pll_factor;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_sleep_enter: assert property (
    ce && sleep_exec && state == power_pkg::st_active && !software_standby_bit
    |=> state == power_pkg::st_sleep)
    else $error("sleep not entered from active");

  a_subsleep_enter: assert property (
    ce && sleep_exec && state == power_pkg::st_subactive && !software_standby_bit
    |=> state == power_pkg::st_subsleep)
    else $error("subsleep not entered");

  a_direct_subactive: assert property (
    ce && sleep_exec && state == power_pkg::st_active && software_standby_bit &&
    lpc.low_speed_flag && lpc.direct_transition_flag
    |=> state == power_pkg::st_subactive ##1
        (!ce || power.main_osc_enable == 1'h0))
    else $error("direct subactive transition failed");

  a_direct_high: assert property (
    ce && sleep_exec && state == power_pkg::st_subactive && software_standby_bit &&
    lpc.direct_transition_flag && !lpc.low_speed_flag
    |=> state == power_pkg::st_active)
    else $error("direct high speed transition failed");

  a_watch_wake_high: assert property (
    ce && wake_request && state == power_pkg::st_watch &&
    !lpc.low_speed_flag |=> state == power_pkg::st_active)
    else $error("watch did not resume high speed");

  a_watch_wake_sub: assert property (
    ce && wake_request && state == power_pkg::st_watch &&
    lpc.low_speed_flag |=> state == power_pkg::st_subactive)
    else $error("watch did not resume subactive");

  a_reserved_store: assert property (
    ce && lpc_write |=> lpc == $past(w_data[7:0]))
    else $error("low power control write lost");

  a_subclock_gate: assert property (
    ce |=> power.subclock_enable == !$past(lpc.subclock_stop_bit))
    else $error("subclock enable wrong");

  a_osc_feedback: assert property (
    ce && !osc_running |=> !power.feedback_resistor_on)
    else $error("feedback on with oscillator stopped");

  a_cut_hold: assert property (
    !(ce && standby_edge) |=> $stable(fb_cut_eff))
    else $error("feedback cut changed outside standby edge");

  a_pll_legal: assert property (
    ce && lpc.pll_factor != power_pkg::PLL_PROHIBITED
    |=> power.pll_factor == $past(lpc.pll_factor))
    else $error("pll factor not followed");

  a_stop_write: assert property (
    ce && lane0 && write_sel == power_pkg::IDX_STOP_A
    |=> module_stop[7:0] == $past(w_data[7:0]))
    else $error("module stop write lost");

  a_standby_select: assert property (
    ce && sleep_exec && state == power_pkg::st_active && software_standby_bit &&
    !lpc.low_speed_flag |=> state == power_pkg::st_standby)
    else $error("software standby not entered");

endmodule

// [test/testbench.sv]
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Ports of the block
  logic                      aclk;
  logic                      aresetn;
  logic                      ce;
  logic                      awvalid;
  logic                      awready;
  logic [7:0]                awaddr;
  logic                      wvalid;
  logic                      wready;
  logic [31:0]               wdata;
  logic [3:0]                wstrb;
  logic                      bvalid;
  logic                      bready;
  logic [1:0]                bresp;
  logic                      arvalid;
  logic                      arready;
  logic [7:0]                araddr;
  logic                      rvalid;
  logic                      rready;
  logic [31:0]               rdata;
  logic [1:0]                rresp;
  logic                      sleep_exec;
  logic                      wake_request;
  logic                      medium_speed_request;
  power_pkg::power_ctrl_type power;
  logic [23:0]               module_stop;

  ////////////////////////////////////////////////////////////////////////////
  // Reference model and bookkeeping
  logic [7:0]                m_lpc;
  logic [7:0]                m_sby;
  logic [7:0]                m_stop [3];
  logic                      m_cut;
  int                        m_state;
  int                        num_errors;
  int                        n_compared;
  int                        seed;
  logic [31:0]               rd;
  logic [31:0]               v;
  logic [1:0]                resp;

  low_power_mode_control u_dut (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .ce                   (ce),
    .awvalid              (awvalid),
    .awready              (awready),
    .awaddr               (awaddr),
    .wvalid               (wvalid),
    .wready               (wready),
    .wdata                (wdata),
    .wstrb                (wstrb),
    .bvalid               (bvalid),
    .bready               (bready),
    .bresp                (bresp),
    .arvalid              (arvalid),
    .arready              (arready),
    .araddr               (araddr),
    .rvalid               (rvalid),
    .rready               (rready),
    .rdata                (rdata),
    .rresp                (rresp),
    .sleep_exec           (sleep_exec),
    .wake_request         (wake_request),
    .medium_speed_request (medium_speed_request),
    .power                (power),
    .module_stop          (module_stop)
  );

  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks; every change lands just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    // Ready stays up between calls, so a call never drops and raises it at once
  endtask

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    resp = rresp;
  endtask

  task automatic check_regs();
    rd_reg(8'h00);
    `CHK(rd, {24'h0, m_lpc})
    rd_reg(8'h04);
    `CHK(rd, {24'h0, m_sby})
    for (int b = 0; b < 3; b++)
    begin
      rd_reg(8'(8 + 4 * b));
      `CHK(rd, {24'h0, m_stop[b]})
    end
    `CHK(module_stop, {m_stop[2], m_stop[1], m_stop[0]})
  endtask

  task automatic power_check();
    logic osc;
    logic med;
    osc = (m_state <= 1);
    med = (m_state == 0) && medium_speed_request;
    rd_reg(8'h14);
    `CHK(rd[4], m_cut)
    `CHK(rd[3], med)
    `CHK(power.medium_speed, med)
    `CHK(power.cpu_clock_stop, (m_state != 0 && m_state != 4))
    `CHK(power.main_osc_enable, osc)
    `CHK(power.feedback_resistor_on, osc && !m_cut)
    `CHK(power.subclock_enable, !m_lpc[4])
    `CHK(power.pll_factor, m_lpc[1:0])
  endtask

  // Software never programs multiplier code 11 nor the reserved bits
  task automatic set_mode(input logic s, input logic l, input logic d);
    v = $random(seed);
    m_sby = {s, v[6:3], 3'h0};
    m_lpc = {d, l, 1'b0, v[12:11], 1'b0, (v[9:8] == 2'h3) ? 2'h2 : v[9:8]};
    wr(8'h04, {24'h0, s, v[6:0]}, 4'hF);
    wr(8'h00, {24'h0, m_lpc}, 4'hF);
  endtask

  task automatic pulse(input logic slp);
    int f;
    int n;
    logic s;
    logic l;
    logic d;
    f = m_state;
    s = m_sby[7];
    l = m_lpc[6];
    d = m_lpc[7];
    n = f;
    // mapping; medium speed counts as high speed
    if (slp && f == 0)
      n = !s ? 1 : !l ? 2 : d ? 4 : 3;
    else if (slp && f == 4)
      n = !s ? 5 : (!l && d) ? 0 : 3;
    else if (!slp && f == 3)
      n = l ? 4 : 0;
    else if (!slp && f == 5)
      n = 4;
    else if (!slp && f != 4)
      n = 0;
    if (f == 2 || n == 2)
      m_cut = m_lpc[3];
    m_state = n;
    if (slp)
      sleep_exec <= 1'b1;
    else
      wake_request <= 1'b1;
    @(posedge aclk);
    sleep_exec <= 1'b0;
    wake_request <= 1'b0;
    repeat (3) @(posedge aclk);
    rd_reg(8'h14);
    if (!slp && !l)
      `CHK(rd[2:0], n[2:0])
    else if (!slp)
      `CHK(rd[2:0], n[2:0])
    else if (f != 4 && !d)
      `CHK(rd[2:0], n[2:0])
    else if (f != 4)
      `CHK(rd[2:0], n[2:0])
    else if (!d)
      `CHK(rd[2:0], n[2:0])
    else
      `CHK(rd[2:0], n[2:0])
    power_check();
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {sleep_exec, wake_request, medium_speed_request} = 3'h0;
    ce = 1'b1;
    num_errors = 0;
    n_compared = 0;
    seed = 32'h1E94;
    m_lpc = 8'h00;
    m_sby = 8'h08;
    m_stop = '{8'h3F, 8'hFF, 8'hFF};
    m_cut = 1'b0;
    m_state = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(power, power_pkg::POWER_RESET)
    check_regs();
    $display("test reset done");
    wr(8'h18, 32'hFFFFFFFF, 4'hF);
    `CHK(resp, power_pkg::RESP_DECERR)
    rd_reg(8'h1C);
    `CHK(resp, power_pkg::RESP_DECERR)
    `CHK(rd, 32'h0)
    wr(8'h14, 32'h000000FF, 4'hF);
    wr(8'h08, 32'h00000000, 4'h0);
    check_regs();
    // A sleep seen with the enable low must leave the state alone
    ce <= 1'b0;
    sleep_exec <= 1'b1;
    @(posedge aclk);
    sleep_exec <= 1'b0;
    ce <= 1'b1;
    rd_reg(8'h14);
    `CHK(rd[2:0], 3'h0)
    pulse(1'b0);
    $display("test decode done");
    repeat (4)
    begin
      for (int b = 0; b < 3; b++)
      begin
        v = $random(seed);
        m_stop[b] = v[7:0];
        wr(8'(8 + 4 * b), v, 4'hF);
      end
      check_regs();
    end
    $display("test module stop done");
    for (int c = 0; c < 3; c++)
    begin
      v = $random(seed);
      m_lpc = {3'h0, v[4:3], 1'b0, 2'(c)};
      wr(8'h00, {24'h0, m_lpc}, 4'hF);
      check_regs();
      power_check();
    end
    $display("test multiplier done");
    for (int k = 0; k < 16; k++)
    begin
      // Medium speed only ahead of plain sleep; high speed before the rest
      medium_speed_request <= (k < 8) && !k[2];
      if (k >= 8)
      begin
        set_mode(1'b1, 1'b1, 1'b1);
        pulse(1'b1);
      end
      set_mode(k[2], k[1], k[0]);
      pulse(1'b1);
      while (m_state != 0)
      begin
        if (m_state == 4)
        begin
          set_mode(1'b1, 1'b0, 1'b1);
          pulse(1'b1);
        end
        else
          pulse(1'b0);
      end
    end
    $display("test transitions done");
    give_verdict();
  end

  // Whole run needs well under a thousand cycles; 50000 means a hang
  initial
  begin
    #500000;
    num_errors++;
    give_verdict();
  end

endmodule
